//--- bench/ext_bus_model.sv
// External bus master model: address and active-low read/write strobes.
// Assumes the bench changes its requests just after a rising pclk edge.
`timescale 1ns/1ps
module ext_bus_model
(
   input wire logic pclk,
   input wire logic [15:0] req_addr,
   input wire logic req_rd,
   input wire logic req_wr,
   output logic [15:0] ext_addr,
   output logic ext_rd_n,
   output logic ext_wr_n
);
   logic [15:0] last_r = 16'h0000; // Address of the latest access
   logic busy; // An access is on the bus
   assign busy = req_rd | req_wr;
   // Remember the address in flight
   always_ff @(posedge pclk)
      if (busy)
         last_r <= req_addr;
   // Idle bus shows no stale address, so a decoder cannot lean on it
   assign ext_addr = busy ? req_addr : ~last_r;
   // Strobes have pull-ups: high while idle
   assign ext_rd_n = ~req_rd;
   assign ext_wr_n = ~req_wr;
endmodule : ext_bus_model

//--- bench/port_chip_select_decoder_tb.sv
// Self-checking bench for the four-pin chip-select port.
// Assumes APB answers by pready; external bus comes from ext_bus_model.
`timescale 1ns/1ps
module port_chip_select_decoder_tb;
   logic pclk = 1'b0; // Bus clock
   logic presetn = 1'b0; // Reset, active low
   logic clk_en = 1'b1; // Clock enable, high runs
   logic [3:0] pstrb = 4'hF; // Byte strobes of a write
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] req_addr = 16'h0; // Access asked of the bus model
   logic req_rd = 1'b0;
   logic req_wr = 1'b0;
   logic [15:0] ext_addr;
   logic ext_rd_n;
   logic ext_wr_n;
   logic [3:0] pin_out;
   int err_count = 0; // Mismatches
   int checked = 0; // Comparisons

   // 100 MHz clock
   always #5 pclk = ~pclk;

   port_chip_select_decoder i_dut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_addr(ext_addr),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n), .pin_out(pin_out));

   ext_bus_model i_ext (.pclk(pclk), .req_addr(req_addr),
      .req_rd(req_rd), .req_wr(req_wr), .ext_addr(ext_addr),
      .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n));

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   // Byte address of a register index
   function automatic logic [31:0] addr_of(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction : addr_of

   // One APB transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      // Answer taken at the very edge that samples pready high
      chk("pready", 32'h1, {31'h0, pready});
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Write expecting no error
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      chk("write error", 32'h0, {31'h0, err});
   endtask : wr

   // Read and compare data and error flag
   task automatic rdc(input logic [31:0] a, input logic [31:0] e,
      input logic ee);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      chk("read data", e, rd);
      chk("read error", {31'h0, ee}, {31'h0, err});
   endtask : rdc

   // One external access: pins while active, then once idle again
   task automatic ext(input logic [15:0] a, input logic r, input logic w,
      input logic [3:0] act, input logic [3:0] idle);
      @(posedge pclk);
      req_addr <= a;
      req_rd <= r;
      req_wr <= w;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("pin active", {28'h0, act}, {28'h0, pin_out});
      @(posedge pclk);
      req_rd <= 1'b0;
      req_wr <= 1'b0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("pin idle", {28'h0, idle}, {28'h0, pin_out});
   endtask : ext

   // Values after reset
   task automatic t_reset;
      chk("pin reset", 32'hF, {28'h0, pin_out});
      rdc(addr_of(strobe_pkg::IDX_POLARITY), 32'h00, 1'b0);
      rdc(addr_of(strobe_pkg::IDX_LOW_CTRL), 32'h00, 1'b0);
      rdc(addr_of(strobe_pkg::IDX_HIGH_CTRL), 32'h00, 1'b0);
      rdc(addr_of(strobe_pkg::IDX_DATA), 32'hFF, 1'b0);
      for (int i = 0; i < 8; i++)
         rdc(addr_of(strobe_pkg::IDX_BASE + 8'(i)), 32'h0, 1'b0);
      $display("test reset done");
   endtask : t_reset

   // Access kinds, reserved bits, unmapped and misaligned places
   task automatic t_regs;
      logic [31:0] rd;
      logic err;
      wr(addr_of(strobe_pkg::IDX_POLARITY), 32'hFF);
      rdc(addr_of(strobe_pkg::IDX_POLARITY), 32'hF0, 1'b0);
      wr(addr_of(strobe_pkg::IDX_LOW_CTRL), 32'hA5);
      rdc(addr_of(strobe_pkg::IDX_LOW_CTRL), 32'hA5, 1'b0);
      for (int i = 0; i < 8; i++)
         wr(addr_of(strobe_pkg::IDX_BASE + 8'(i)), 32'h11 * (i + 1));
      for (int i = 0; i < 8; i++)
         rdc(addr_of(strobe_pkg::IDX_BASE + 8'(i)), 32'h11 * (i + 1),
            1'b0);
      rdc(32'h4, 32'h0, 1'b1);
      apb(1'b1, addr_of(strobe_pkg::IDX_LOW_CTRL) + 32'h1, 32'h00, rd, err);
      chk("misaligned error", 32'h1, {31'h0, err});
      rdc(addr_of(strobe_pkg::IDX_LOW_CTRL), 32'hA5, 1'b0);
      $display("test regs done");
   endtask : t_regs

   // General-purpose pins follow data bits, ignore the bus
   task automatic t_gpio;
      wr(addr_of(strobe_pkg::IDX_LOW_CTRL), 32'h00);
      wr(addr_of(strobe_pkg::IDX_DATA), 32'h5A);
      rdc(addr_of(strobe_pkg::IDX_DATA), 32'h5A, 1'b0);
      ext(16'h2211, 1'b1, 1'b1, 4'hA, 4'hA);
      $display("test gpio done");
   endtask : t_gpio

   // Clock enable low freezes a write; cleared byte strobe drops one
   task automatic t_gate;
      @(posedge pclk);
      clk_en <= 1'b0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= 1'b1;
      paddr <= addr_of(strobe_pkg::IDX_DATA);
      pwdata <= 32'h0;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk("frozen pready", 32'h0, {31'h0, pready});
      chk("frozen pin", 32'hA, {28'h0, pin_out});
      @(posedge pclk);
      clk_en <= 1'b1;
      psel <= 1'b0;
      pstrb <= 4'hE;
      wr(addr_of(strobe_pkg::IDX_DATA), 32'h00);
      pstrb <= 4'hF;
      rdc(addr_of(strobe_pkg::IDX_DATA), 32'h5A, 1'b0);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      chk("kept pin", 32'hA, {28'h0, pin_out});
      $display("test gate done");
   endtask : t_gate

   // One pin in one mode and compare length
   task automatic t_cfg(input int p, input logic [1:0] f,
      input logic [1:0] c);
      logic [15:0] base;
      logic pol;
      logic [15:0] hit;
      logic [15:0] miss;
      logic [3:0] off;
      logic [3:0] on;
      logic [7:0] fld;
      int m;
      base = {8'h12 + 8'(p), 8'h34 + 8'(p)};
      pol = c[1] ^ f[0];
      m = (c == 2'h3) ? 8 : int'(c);
      hit = (m == 0) ? base : base ^ (16'h1 << (m - 1));
      miss = base ^ (16'h1 << m);
      off = (f == 2'h0) ? 4'h0 : ({3'h0, ~pol} << p);
      on = (f == 2'h0) ? 4'h0 : ({3'h0, pol} << p);
      fld = {4'h0, f, c} << (4 * (p % 2));
      wr(addr_of(strobe_pkg::IDX_BASE + 8'(2 * p)), {24'h0, base[15:8]});
      wr(addr_of(strobe_pkg::IDX_BASE + 8'(2 * p + 1)), {24'h0, base[7:0]});
      wr(addr_of(strobe_pkg::IDX_LOW_CTRL), {24'h0, p < 2 ? fld : 8'h0});
      wr(addr_of(strobe_pkg::IDX_HIGH_CTRL), {24'h0, p > 1 ? fld : 8'h0});
      wr(addr_of(strobe_pkg::IDX_POLARITY), {24'h0, 8'(pol) << (4 + p)});
      ext(hit, 1'b0, 1'b1, f[1] ? on : off, off);
      ext(hit, 1'b1, 1'b0, f[0] ? on : off, off);
      ext(miss, 1'b1, 1'b1, off, off);
   endtask : t_cfg

   // Every pin, every mode, every compare length
   task automatic t_modes;
      wr(addr_of(strobe_pkg::IDX_DATA), 32'h00);
      for (int p = 0; p < 4; p++)
         for (int f = 0; f < 4; f++)
            for (int c = 0; c < 4; c++)
               t_cfg(p, 2'(f), 2'(c));
      $display("test modes done");
   endtask : t_modes

   // Counts, verdict, end of run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // Main sequence
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      t_reset;
      t_regs;
      t_gpio;
      t_gate;
      t_modes;
      give_verdict;
   end

   // Watchdog against a hang
   initial
   begin
      #500us;
      $display("[FAIL] watchdog expected done seen hang");
      err_count++;
      give_verdict;
   end
endmodule : port_chip_select_decoder_tb

//--- hw/port_chip_select_decoder.sv
// Four-pin port: plain data outputs or decoded chip-select strobes.
// Assumes an APB master on pclk; external bus strobes arrive from pins.
//
// Functional notes
// - Function fields for pins 1,0 in control
// - Compare fields for pins 1,0 in control
// - Polarity bit 7 sets pin 3 level
// - Polarity bits 6..4 for pins 2..0
// - Each pin has high and low base bytes
// - Data bits 3..0 drive general-mode pins
// - Ignoring A1,A0 gives four-address window
// - Write mode strobes on matching writes
// - Polarity defaults low; one means high
// - Function codes: gpio, read, write, both
// - Compare lengths: 16, 15, 14, 8 bits
// - Strobe follows read or write strobe
// - High and low bytes form base address
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module port_chip_select_decoder
#(
   parameter int PINS = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] ext_addr,
   input wire logic ext_rd_n,
   input wire logic ext_wr_n,
   output logic [PINS-1:0] pin_out
);

   // Configuration registers
   logic [7:0] polarity_r, polarity_nxt;
   logic [7:0] low_ctrl_r, low_ctrl_nxt;
   logic [7:0] high_ctrl_r, high_ctrl_nxt;
   logic [7:0] data_r, data_nxt;
   logic [7:0] base_hi_r [PINS];
   logic [7:0] base_hi_nxt [PINS];
   logic [7:0] base_lo_r [PINS];
   logic [7:0] base_lo_nxt [PINS];
   // Bus answer registers
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic pslverr_r, pslverr_nxt;
   // External access synchronisers, two stages each
   logic [17:0] ext_s1_r, ext_s2_r;
   strobe_pkg::ext_acc_t acc;
   strobe_pkg::pin_cfg_t cfg [PINS];

   logic [7:0] idx; // Register index from byte address
   logic setup; // APB setup phase seen
   logic known; // Address decodes to a register
   logic [7:0] rd_val; // Register read value
   logic [7:0] boff; // Offset into the base register block

   // Register index and read mux
   always_comb
   begin
      idx = paddr[9:2];
      setup = psel & ~penable;
      known = 1'b1;
      rd_val = 8'h00;
      boff = idx - strobe_pkg::IDX_BASE;
      if (paddr[31:10] != 22'h0 || paddr[1:0] != 2'h0)
      begin
         known = 1'b0;
      end
      else if (idx == strobe_pkg::IDX_POLARITY)
      begin
         rd_val = polarity_r & strobe_pkg::POL_MASK;
      end
      else if (idx == strobe_pkg::IDX_LOW_CTRL)
      begin
         rd_val = low_ctrl_r;
      end
      else if (idx == strobe_pkg::IDX_HIGH_CTRL)
      begin
         rd_val = high_ctrl_r;
      end
      else if (idx == strobe_pkg::IDX_DATA)
      begin
         rd_val = data_r;
      end
      else if (idx >= strobe_pkg::IDX_BASE &&
         idx < strobe_pkg::IDX_BASE + 8'(2 * PINS))
      begin
         // Even offset high byte, odd offset low byte
         if (idx[0] == 1'b0)
         begin
            rd_val = base_hi_r[boff[$clog2(PINS):1]];
         end
         else
         begin
            rd_val = base_lo_r[boff[$clog2(PINS):1]];
         end
      end
      else
      begin
         known = 1'b0;
      end
   end

   // Register writes and the bus answer, one wait-free access cycle
   always_comb
   begin
      polarity_nxt = polarity_r;
      low_ctrl_nxt = low_ctrl_r;
      high_ctrl_nxt = high_ctrl_r;
      data_nxt = data_r;
      base_hi_nxt = base_hi_r;
      base_lo_nxt = base_lo_r;
      prdata_nxt = 32'h0000_0000;
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
      if (setup)
      begin
         // Answer registered at the end of setup, ready in access
         pready_nxt = 1'b1;
         pslverr_nxt = ~known;
         if (!pwrite && known)
         begin
            prdata_nxt = {24'h00_0000, rd_val};
         end
         if (pwrite && known && pstrb[0])
         begin
            if (idx == strobe_pkg::IDX_POLARITY)
            begin
               // Low bits ignore writes
               polarity_nxt = pwdata[7:0] & strobe_pkg::POL_MASK;
            end
            else if (idx == strobe_pkg::IDX_LOW_CTRL)
            begin
               low_ctrl_nxt = pwdata[7:0];
            end
            else if (idx == strobe_pkg::IDX_HIGH_CTRL)
            begin
               high_ctrl_nxt = pwdata[7:0];
            end
            else if (idx == strobe_pkg::IDX_DATA)
            begin
               data_nxt = pwdata[7:0];
            end
            else if (idx[0] == 1'b0)
            begin
               base_hi_nxt[boff[$clog2(PINS):1]] =
                  pwdata[7:0];
            end
            else
            begin
               base_lo_nxt[boff[$clog2(PINS):1]] =
                  pwdata[7:0];
            end
         end
      end
   end

   // Register state; writes land at the setup edge, before completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         polarity_r <= strobe_pkg::RST_POLARITY;
         low_ctrl_r <= strobe_pkg::RST_CTRL;
         high_ctrl_r <= strobe_pkg::RST_CTRL;
         data_r <= strobe_pkg::RST_DATA;
         for (int i = 0; i < PINS; i++)
         begin
            base_hi_r[i] <= strobe_pkg::RST_BASE;
            base_lo_r[i] <= strobe_pkg::RST_BASE;
         end
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else if (clk_en)
      begin
         polarity_r <= polarity_nxt;
         low_ctrl_r <= low_ctrl_nxt;
         high_ctrl_r <= high_ctrl_nxt;
         data_r <= data_nxt;
         base_hi_r <= base_hi_nxt;
         base_lo_r <= base_lo_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;

   // Two-stage sync of the external bus pins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_s1_r <= 18'h0_0000;
         ext_s2_r <= 18'h0_0000;
      end
      else if (clk_en)
      begin
         ext_s1_r <= {ext_addr, ~ext_rd_n, ~ext_wr_n};
         ext_s2_r <= ext_s1_r;
      end
   end

   assign acc = strobe_pkg::ext_acc_t'(ext_s2_r);

   // Per-pin configuration and decoder instances
   for (genvar p = 0; p < PINS; p++)
   begin : g_pin
      logic [7:0] ctrl;
      assign ctrl = (p < 2) ? low_ctrl_r : high_ctrl_r;
      assign cfg[p].base = {base_hi_r[p], base_lo_r[p]};
      assign cfg[p].fun = strobe_pkg::pin_fun_t'(
         ctrl[(p % 2) * strobe_pkg::PIN_FIELD_W + strobe_pkg::FUN_LSB +: 2]);
      assign cfg[p].cmp = strobe_pkg::pin_cmp_t'(
         ctrl[(p % 2) * strobe_pkg::PIN_FIELD_W + strobe_pkg::CMP_LSB +: 2]);
      assign cfg[p].polarity = polarity_r[strobe_pkg::POL_LSB + p];
      assign cfg[p].data = data_r[p];
      strobe_pin u_pin
      (
         .pclk(pclk),
         .presetn(presetn),
         .clk_en(clk_en),
         .cfg(cfg[p]),
         .acc(acc),
         .pin_out(pin_out[p])
      );
   end

   // Reserved polarity bits always read zero
   pol_reserved_a: assert property (@(posedge pclk) disable iff (!presetn)
      polarity_r[3:0] == 4'h0)
      else $error("reserved polarity bits set");

   // Control write visible in the register the cycle after setup
   ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup && pwrite && pstrb[0] && paddr == 32'h0000_0308
      |=> low_ctrl_r == $past(pwdata[7:0]))
      else $error("control write lost");

   // Polarity reads back upper nibble only
   pol_read_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup && !pwrite && paddr == 32'h0000_02B8
      |=> prdata_r == {24'h00_0000, $past(polarity_r) & 8'hF0})
      else $error("polarity readback wrong");

   // Unmapped access answered with error
   unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && setup && paddr[31:10] != 22'h0 |=> pready_r && pslverr_r)
      else $error("unmapped access not refused");

endmodule : port_chip_select_decoder

//--- hw/strobe_pin.sv
// One pin's address decoder and output driver.
// Assumes a synchronised external access and registered configuration.
`timescale 1ns/1ps
module strobe_pin
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire strobe_pkg::pin_cfg_t cfg,
   input wire strobe_pkg::ext_acc_t acc,
   output logic pin_out
);

   logic [15:0] mask; // Address bits taking part in the compare
   logic hit; // Address inside the window
   logic active; // Strobe asserted this cycle
   logic pin_nxt;
   logic pin_r;

   // Mask and strobe qualification
   always_comb
   begin
      case (cfg.cmp)
         strobe_pkg::CMP_FULL: mask = 16'hFFFF;
         strobe_pkg::CMP_A1: mask = 16'hFFFE;
         strobe_pkg::CMP_A2: mask = 16'hFFFC;
         strobe_pkg::CMP_A8: mask = 16'hFF00;
         default: mask = 16'hFFFF;
      endcase
      hit = ((acc.addr ^ cfg.base) & mask) == 16'h0000;
      case (cfg.fun)
         strobe_pkg::FUN_READ: active = hit & acc.rd;
         strobe_pkg::FUN_WRITE: active = hit & acc.wr;
         strobe_pkg::FUN_BOTH: active = hit & (acc.rd | acc.wr);
         default: active = 1'b0;
      endcase
      if (cfg.fun == strobe_pkg::FUN_GPIO)
      begin
         pin_nxt = cfg.data;
      end
      else
      begin
         // Inactive level is the inverse of the active one
         pin_nxt = active ? cfg.polarity : ~cfg.polarity;
      end
   end

   // Output register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_r <= 1'b1;
      end
      else if (clk_en)
      begin
         pin_r <= pin_nxt;
      end
   end

   assign pin_out = pin_r;

   // Write-strobe hit shows active level next cycle
   wr_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cfg.fun == strobe_pkg::FUN_WRITE && acc.wr &&
      ((acc.addr ^ cfg.base) & mask) == 16'h0000
      |=> pin_r == $past(cfg.polarity))
      else $error("write strobe not asserted");

   // Idle strobe pin sits at inactive level
   idle_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cfg.fun != strobe_pkg::FUN_GPIO && !acc.rd && !acc.wr
      |=> pin_r == !$past(cfg.polarity))
      else $error("strobe pin not idle");

   // General mode follows the data bit
   gpio_data_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cfg.fun == strobe_pkg::FUN_GPIO
      |=> pin_r == $past(cfg.data))
      else $error("gpio pin not following data");

   // Byte-window compare hits for any low byte
   byte_window_a: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && cfg.cmp == strobe_pkg::CMP_A8 && acc.rd &&
      cfg.fun == strobe_pkg::FUN_READ && acc.addr[15:8] == cfg.base[15:8]
      |=> pin_r == $past(cfg.polarity))
      else $error("byte window missed");

endmodule : strobe_pin

//--- hw/strobe_pkg.sv
// Constants and carrier types for the four-pin chip-select port.
// Assumes an APB slave with 32-bit data and one word per register.
package strobe_pkg;

   // Printed register indices; byte address is four times the index
   localparam logic [7:0] IDX_POLARITY = 8'hAE;
   localparam logic [7:0] IDX_LOW_CTRL = 8'hC2;
   localparam logic [7:0] IDX_HIGH_CTRL = 8'hC3;
   localparam logic [7:0] IDX_DATA = 8'hD8;
   // Base registers: high byte at IDX_BASE + 2*pin, low at +1
   localparam logic [7:0] IDX_BASE = 8'hE0;

   // Values after reset
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [7:0] RST_DATA = 8'hFF;
   localparam logic [7:0] RST_BASE = 8'h00;

   // Polarity register: writable bits 7..4, low bits read zero
   localparam logic [7:0] POL_MASK = 8'hF0;
   localparam int POL_LSB = 4;

   // Field positions inside a control register, per pin within it
   localparam int FUN_LSB = 2;
   localparam int CMP_LSB = 0;
   localparam int PIN_FIELD_W = 4;

   // Pin function encoding
   typedef enum logic [1:0]
   {
      FUN_GPIO = 2'h0,
      FUN_READ = 2'h1,
      FUN_WRITE = 2'h2,
      FUN_BOTH = 2'h3
   } pin_fun_t;

   // Compare-length encoding
   typedef enum logic [1:0]
   {
      CMP_FULL = 2'h0,
      CMP_A1 = 2'h1,
      CMP_A2 = 2'h2,
      CMP_A8 = 2'h3
   } pin_cmp_t;

   // Per-pin configuration carried to the comparator
   typedef struct packed
   {
      logic [15:0] base;
      pin_fun_t fun;
      pin_cmp_t cmp;
      logic polarity;
      logic data;
   } pin_cfg_t;

   // External bus access, already synchronised
   typedef struct packed
   {
      logic [15:0] addr;
      logic rd;
      logic wr;
   } ext_acc_t;

endpackage : strobe_pkg
